// ===== core/eio_strobe_port.sv
`timescale 1ns/100ps
module eio_strobe_port (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        req_i,
  input  wire logic        req_write_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [15:0] req_wdata_i,
  output logic             ack_o,
  output logic      [15:0] rdata_o,
  input  wire logic        cs_zero_gpio_i,
  input  wire logic        cs_one_gpio_i,
  input  wire logic        emulation_mode_i,
  output logic             emulation_strobe_o,
  output logic             ext_chip_select_zero_n_o,
  output logic             ext_chip_select_one_n_o,
  output logic             output_enable_n_o,
  output logic             latch_write_strobe_n_o,
  output logic      [15:0] ext_addr_o,
  output logic      [15:0] ext_data_o,
  output logic             ext_data_oe_n_o,
  input  wire logic [15:0] ext_data_i
);
  import eio_pkg::*;

  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  logic [31:0] latch_port_timing_ctrl;
  logic [31:0] chip_window_timing_ctrl;
  logic [15:0] latch_port_data;
  logic [15:0] ext_read_data;
  eio_state_t  state;
  logic [3:0]  count;
  logic        cur_is_port;
  logic        cur_is_one;
  logic        cur_write;
  logic        cur_wide;
  logic [31:0] cur_timing;
  logic [3:0]  setup_cnt;
  logic [3:0]  hold_cnt;
  logic [3:0]  access_cnt;
  logic        hit_port;
  logic        hit_win;
  logic        hit_one;
  logic        in_space;
  logic        win_enabled;
  logic [1:0]  win_width;
  logic [1:0]  port_width;
  logic        start;
  logic [31:0] next_timing;

  assign in_space = (req_addr_i >= EIO_WINDOW_BASE) && (req_addr_i <= EIO_WINDOW_LIMIT);
  assign next_timing = hit_port ? latch_port_timing_ctrl : chip_window_timing_ctrl;
  assign hit_port = req_addr_i == EIO_LATCH_DATA_OFS;
  assign hit_win = in_space && ((req_addr_i[5:0] == EIO_WINDOW_ZERO_LOW)
                   || (req_addr_i[5:0] == EIO_WINDOW_ONE_LOW));
  assign hit_one = req_addr_i[5:0] == EIO_WINDOW_ONE_LOW;
  assign win_width = chip_window_timing_ctrl[EIO_WIDTH_LSB +: 2];
  assign port_width = latch_port_timing_ctrl[EIO_WIDTH_LSB +: 2];
  // unused code 11 treated as disabled
  assign win_enabled = ((win_width == EIO_WIDTH_8) || (win_width == EIO_WIDTH_16))
                       && !(hit_one ? cs_one_gpio_i : cs_zero_gpio_i);
  // no new request while the answer of the previous one still stands
  assign start = req_i && (state == EIO_IDLE) && !ack_o
                 && ((hit_win && win_enabled)
                 || (hit_port && req_write_i && ((port_width == EIO_WIDTH_8) || (port_width == EIO_WIDTH_16))));

  // ----------------------------------------
  // timing registers and latch data
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      latch_port_timing_ctrl <= EIO_TIMING_RESET;
      chip_window_timing_ctrl <= EIO_TIMING_RESET;
      latch_port_data <= EIO_LATCH_DATA_RESET;
    end
    else if (req_i && req_write_i && (state == EIO_IDLE) && !ack_o)
    begin
      if (req_addr_i == EIO_LATCH_TIMING_OFS)
        latch_port_timing_ctrl <= {18'h0, req_wdata_i[13:8], 3'h0, req_wdata_i[4:0]};
      if (req_addr_i == EIO_WINDOW_TIMING_OFS)
        chip_window_timing_ctrl <= {18'h0, req_wdata_i[13:8], 3'h0, req_wdata_i[4:0]};
      if (hit_port)
        latch_port_data <= req_wdata_i;
    end
  end

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  eio_timing_count u_count (
    .timing_i     (cur_timing),
    .setup_cnt_o  (setup_cnt),
    .hold_cnt_o   (hold_cnt),
    .access_cnt_o (access_cnt)
  );

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= EIO_IDLE;
      count <= 4'h0;
      cur_is_port <= 1'b0;
      cur_is_one <= 1'b0;
      cur_write <= 1'b0;
      cur_wide <= 1'b0;
      cur_timing <= EIO_TIMING_RESET;
      ext_addr_o <= 16'h0000;
      ext_data_o <= 16'h0000;
    end
    else
    begin
      unique case (state)
        EIO_IDLE:
        begin
          count <= 4'h1;
          if (start)
          begin
            // zero set-up goes straight to the enable phase, or to hold when the access field is zero too
            if (next_timing[EIO_SETUP_LSB +: 3] != 3'h0)
              state <= EIO_SETUP;
            else if (next_timing[EIO_ACCESS_LSB +: 3] != 3'h0)
              state <= EIO_ACCESS;
            else
              state <= EIO_HOLD;
            cur_is_port <= hit_port;
            cur_is_one <= hit_one;
            cur_write <= req_write_i;
            cur_timing <= hit_port ? latch_port_timing_ctrl
                                   : chip_window_timing_ctrl;
            cur_wide <= (hit_port ? port_width : win_width) == EIO_WIDTH_16;
            ext_addr_o <= req_addr_i;
            ext_data_o <= req_wdata_i;
          end
        end
        EIO_SETUP:
          if (count >= setup_cnt)
          begin
            if (access_cnt != 4'h0)
              state <= EIO_ACCESS;
            else if (hold_cnt != 4'h0)
              state <= EIO_HOLD;
            else
              state <= EIO_DONE;
            count <= 4'h1;
          end
          else
            count <= count + 4'h1;
        EIO_ACCESS:
          if (count >= access_cnt)
          begin
            // zero hold releases the select right after the enable
            state <= (hold_cnt != 4'h0) ? EIO_HOLD : EIO_DONE;
            count <= 4'h1;
          end
          else
            count <= count + 4'h1;
        EIO_HOLD:
          if (count >= hold_cnt)
            state <= EIO_DONE;
          else
            count <= count + 4'h1;
        EIO_DONE:
          state <= EIO_IDLE;
        default:
          state <= EIO_IDLE;
      endcase
    end
  end

  // capture read data at the end of the enable phase
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ext_read_data <= 16'h0000;
    else if ((state == EIO_ACCESS) && (count >= access_cnt) && !cur_write)
      ext_read_data <= cur_wide ? ext_data_i : {8'h00, ext_data_i[7:0]};
  end

  // ----------------------------------------
  // cpu answer
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ack_o <= 1'b0;
      rdata_o <= 16'h0000;
    end
    else
    begin
      ack_o <= 1'b0;
      if (state == EIO_DONE)
      begin
        ack_o <= 1'b1;
        rdata_o <= cur_is_port ? latch_port_data : ext_read_data;
      end
      else if (req_i && (state == EIO_IDLE) && !start && !ack_o)
      begin
        ack_o <= 1'b1;
        if (req_addr_i == EIO_LATCH_TIMING_OFS)
          rdata_o <= latch_port_timing_ctrl[15:0];
        else if (req_addr_i == EIO_WINDOW_TIMING_OFS)
          rdata_o <= chip_window_timing_ctrl[15:0];
        else if (hit_port)
          rdata_o <= latch_port_data;
        else
          rdata_o <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  logic busy;
  logic oe_phase;

  assign busy = (state == EIO_SETUP) || (state == EIO_ACCESS) || (state == EIO_HOLD);
  assign oe_phase = state == EIO_ACCESS;
  assign ext_chip_select_zero_n_o = !(busy && !cur_is_port && !cur_is_one);
  assign ext_chip_select_one_n_o = !(busy && !cur_is_port && cur_is_one);
  assign output_enable_n_o = !(oe_phase && !cur_is_port && !cur_write);
  assign latch_write_strobe_n_o = !(oe_phase && cur_is_port);
  assign emulation_strobe_o = emulation_mode_i && oe_phase && cur_is_port;
  assign ext_data_oe_n_o = !(busy && cur_write);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cs_one_hot_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !(!ext_chip_select_zero_n_o && !ext_chip_select_one_n_o))
    else $error("both chip selects low");
  oe_inside_cs_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !output_enable_n_o |-> (!ext_chip_select_zero_n_o || !ext_chip_select_one_n_o))
    else $error("enable outside chip select");
  strobe_on_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (req_i && req_write_i && hit_port && start) |-> ##[1:9] !latch_write_strobe_n_o)
    else $error("latch strobe missing");
  disabled_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (req_i && (state == EIO_IDLE) && hit_win && !win_enabled) |=> (state == EIO_IDLE))
    else $error("disabled bank started a cycle");
  gpio_no_cs_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ((state == EIO_IDLE) && req_i && hit_win && (hit_one ? cs_one_gpio_i : cs_zero_gpio_i))
    |=> (ext_chip_select_zero_n_o && ext_chip_select_one_n_o))
    else $error("chip select on gpio pin");
  access_done_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state == EIO_SETUP) |-> ##[1:24] ack_o)
    else $error("external cycle never answered");
endmodule

// ===== core/eio_pkg.sv
package eio_pkg;
  // register offsets
  localparam logic [15:0] EIO_LATCH_TIMING_OFS = 16'h2030;
  localparam logic [15:0] EIO_WINDOW_TIMING_OFS = 16'h2034;
  localparam logic [15:0] EIO_LATCH_DATA_OFS = 16'h203e;
  // window decode: offsets 0x2000..0x2fff, low six bits 0x2c / 0x2e
  localparam logic [15:0] EIO_WINDOW_BASE = 16'h2000;
  localparam logic [15:0] EIO_WINDOW_LIMIT = 16'h2fff;
  localparam logic [5:0]  EIO_WINDOW_ZERO_LOW = 6'h2c;
  localparam logic [5:0]  EIO_WINDOW_ONE_LOW = 6'h2e;
  localparam int          EIO_WINDOW_BYTES = 64;
  // field positions
  localparam int EIO_WIDTH_LSB = 0;
  localparam int EIO_SETUP_LSB = 2;
  localparam int EIO_HOLD_LSB = 8;
  localparam int EIO_ACCESS_LSB = 11;
  // reset values
  localparam logic [31:0] EIO_TIMING_RESET = 32'h0000_0000;
  localparam logic [15:0] EIO_LATCH_DATA_RESET = 16'h0000;
  // width codes
  localparam logic [1:0] EIO_WIDTH_OFF = 2'h0;
  localparam logic [1:0] EIO_WIDTH_8 = 2'h1;
  localparam logic [1:0] EIO_WIDTH_16 = 2'h2;

  typedef enum logic [2:0] {
    EIO_IDLE   = 3'b000,
    EIO_SETUP  = 3'b001,
    EIO_ACCESS = 3'b010,
    EIO_HOLD   = 3'b011,
    EIO_DONE   = 3'b100
  } eio_state_t;
endpackage

// ===== core/eio_timing_count.sv
`timescale 1ns/100ps
// decodes the three timing fields into clock counts
module eio_timing_count (
  input  wire logic [31:0] timing_i,
  output logic      [3:0]  setup_cnt_o,
  output logic      [3:0]  hold_cnt_o,
  output logic      [3:0]  access_cnt_o
);
  import eio_pkg::*;

  logic [2:0] setup_code;
  logic [2:0] hold_code;
  logic [2:0] access_code;

  assign setup_code = timing_i[EIO_SETUP_LSB +: 3];
  assign hold_code = timing_i[EIO_HOLD_LSB +: 3];
  assign access_code = timing_i[EIO_ACCESS_LSB +: 3];

  assign setup_cnt_o = {1'b0, setup_code};
  assign hold_cnt_o = (hold_code < 3'h2) ? 4'h0 : {1'b0, hold_code};
  assign access_cnt_o = (access_code == 3'h0) ? 4'h0 : {1'b0, access_code} + 4'h1;
endmodule

// ===== test/eio_ext_dev_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// external i/o device and output latch
// ----------------------------------------
module eio_ext_dev_model (
  input  wire logic        core_clk_i,
  input  wire logic        cs_zero_n_i,
  input  wire logic        cs_one_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        strobe_n_i,
  input  wire logic        data_oe_n_i,
  input  wire logic [15:0] data_i,
  output logic      [15:0] data_o,
  output logic      [15:0] latch_o
);
  logic [15:0] mem_zero = 16'h0000;
  logic [15:0] mem_one  = 16'h0000;
  logic [15:0] last     = 16'h0000;
  logic        rd_on;
  assign rd_on = !oe_n_i && (!cs_zero_n_i || !cs_one_n_i);
  // released bus shows the inverse of the last value
  assign data_o = rd_on ? (!cs_zero_n_i ? mem_zero : mem_one) : ~last;
  always @(posedge core_clk_i)
  begin
    if (rd_on) last <= data_o;
    if (!data_oe_n_i && !cs_zero_n_i) mem_zero <= data_i;
    if (!data_oe_n_i && !cs_one_n_i) mem_one <= data_i;
  end
  initial latch_o = 16'h0000;
  always @(posedge strobe_n_i) latch_o <= data_i;
endmodule

// ===== test/external_io_strobe_interface_tb.sv
`timescale 1ns/100ps
module external_io_strobe_interface_tb;
  import eio_pkg::*;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, req_i = 1'b0, req_write_i = 1'b0;
  logic [15:0] req_addr_i = 16'h0000, req_wdata_i = 16'h0000, rdata_o, ext_addr_o, ext_data_o, ext_data_i, latch;
  logic cs_zero_gpio_i = 1'b0, cs_one_gpio_i = 1'b0, emulation_mode_i = 1'b0;
  logic ack_o, emu_o, cs0_n, cs1_n, oe_n, str_n, doe_n;
  int n_mismatch = 0, comparisons = 0, n_cs, n_oe, n_pre, n_str, n_emu;
  logic [15:0] rd;
  always #5 core_clk_i = ~core_clk_i;
  eio_strobe_port u_eio_strobe_port (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ack_o(ack_o),
    .rdata_o(rdata_o), .cs_zero_gpio_i(cs_zero_gpio_i), .cs_one_gpio_i(cs_one_gpio_i),
    .emulation_mode_i(emulation_mode_i), .emulation_strobe_o(emu_o), .ext_chip_select_zero_n_o(cs0_n),
    .ext_chip_select_one_n_o(cs1_n), .output_enable_n_o(oe_n), .latch_write_strobe_n_o(str_n),
    .ext_addr_o(ext_addr_o), .ext_data_o(ext_data_o), .ext_data_oe_n_o(doe_n), .ext_data_i(ext_data_i));
  eio_ext_dev_model u_eio_ext_dev_model (.core_clk_i(core_clk_i), .cs_zero_n_i(cs0_n), .cs_one_n_i(cs1_n),
    .oe_n_i(oe_n), .strobe_n_i(str_n), .data_oe_n_i(doe_n), .data_i(ext_data_o), .data_o(ext_data_i),
    .latch_o(latch));
  // ----------------------------------------
  // pin activity counters
  // ----------------------------------------
  always @(negedge core_clk_i)
  begin
    if (cs0_n === 1'b0 || cs1_n === 1'b0) n_cs++;
    if (oe_n === 1'b0) n_oe++;
    if ((cs0_n === 1'b0 || cs1_n === 1'b0) && oe_n === 1'b1 && n_oe == 0) n_pre++;
    if (str_n === 1'b0) n_str++;
    if (emu_o === 1'b1) n_emu++;
  end
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    int i;
    n_cs = 0; n_oe = 0; n_pre = 0; n_str = 0; n_emu = 0;
    @(posedge core_clk_i);
    req_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= addr;
    req_wdata_i <= data;
    for (i = 0; i < 300; i++)
    begin
      @(posedge core_clk_i);
      if (ack_o === 1'b1)
        break;
    end
    if (ack_o !== 1'b1)
    begin
      n_mismatch++;
      close_out();
    end
    rd = rdata_o;
    req_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    acc(0, EIO_LATCH_TIMING_OFS, 0); chk(rd, 16'h0000);
    acc(0, EIO_WINDOW_TIMING_OFS, 0); chk(rd, 16'h0000);
    acc(0, EIO_LATCH_DATA_OFS, 0); chk(rd, 16'h0000);
    acc(1, 16'h206c, 16'h12ff); chk(16'(n_cs), 16'h0000);
    acc(1, EIO_WINDOW_TIMING_OFS, 16'h0a0a);
    acc(0, EIO_WINDOW_TIMING_OFS, 0); chk(rd, 16'h0a0a);
    acc(1, 16'h206c, 16'h12ff); chk(u_eio_ext_dev_model.mem_zero, 16'h12ff);
    chk(ext_addr_o, 16'h206c);
    acc(1, 16'h2fee, 16'h3456); chk(u_eio_ext_dev_model.mem_one, 16'h3456);
    acc(0, 16'h202c, 0); chk(rd, 16'h12ff);
    chk(16'(n_pre), 16'h0002);
    chk(16'(n_oe), 16'h0002);
    chk(16'(n_cs - n_oe - n_pre), 16'h0002);
    acc(0, 16'h20ae, 0); chk(rd, 16'h3456);
    acc(1, EIO_WINDOW_TIMING_OFS, 16'h0a09);
    acc(0, 16'h202c, 0); chk(rd, 16'h00ff);
    cs_zero_gpio_i <= 1'b1;
    acc(0, 16'h202c, 0); chk(16'(n_cs), 16'h0000);
    chk(rd, 16'h0000);
    cs_zero_gpio_i <= 1'b0;
    acc(1, EIO_WINDOW_TIMING_OFS, 16'h0a0b);
    acc(0, 16'h202e, 0); chk(16'(n_cs), 16'h0000);
    acc(1, EIO_LATCH_TIMING_OFS, 16'h1801);
    emulation_mode_i <= 1'b1;
    acc(1, EIO_LATCH_DATA_OFS, 16'h00a5); chk(latch, 16'h00a5);
    chk(16'(n_str), 16'h0004);
    chk(16'(n_emu), 16'h0004);
    chk(16'(n_cs), 16'h0000);
    emulation_mode_i <= 1'b0;
    acc(1, EIO_LATCH_DATA_OFS, 16'h005a); chk(16'(n_emu), 16'h0000);
    acc(1, EIO_LATCH_TIMING_OFS, 16'h1800);
    acc(1, EIO_LATCH_DATA_OFS, 16'h0033); chk(16'(n_str), 16'h0000);
    acc(0, EIO_LATCH_DATA_OFS, 0); chk(rd, 16'h0033);
    acc(0, 16'h2040, 0); chk(rd, 16'h0000);
    close_out();
  end
endmodule
